// >>> inc/timer16_map.svh
// register offsets, field positions, reset values and timing counts of the timer
// assumes an AHB-Lite word-per-register map, included by bare name
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH
`define OFS_CTRL_A 12'h000
`define OFS_CTRL_B 12'h004
`define OFS_CTRL_C 12'h008
`define OFS_CNT_LO 12'h00C
`define OFS_CNT_HI 12'h010
`define OFS_CMP0_LO 12'h014
`define OFS_CMP0_HI 12'h018
`define OFS_CMP1_LO 12'h01C
`define OFS_CMP1_HI 12'h020
`define OFS_CMP2_LO 12'h024
`define OFS_CMP2_HI 12'h028
`define OFS_CAP_LO 12'h02C
`define OFS_CAP_HI 12'h030
`define OFS_FLAG 12'h034
`define OFS_MASK 12'h038
`define OFS_POWER 12'h03C
`define CTRL_B_CS_LSB 0
`define CTRL_B_CEIL_LSB 3
`define CTRL_B_FILT_BIT 6
`define CTRL_B_CAPSRC_BIT 7
`define CTRL_C_CAPEDGE_BIT 0
`define FLAG_OVF_BIT 0
`define FLAG_CMP_LSB 1
`define FLAG_CAP_BIT 4
`define FLAG_W 5
`define POWER_RST 8'h01
`define CEIL_8BIT 16'h00FF
`define CEIL_9BIT 16'h01FF
`define CEIL_10BIT 16'h03FF
`define COUNT_FLOOR 16'h0000
`define COUNT_MAX 16'hFFFF
`define FILT_LEN 4
`define PRE_DIV8 10'h007
`define PRE_DIV64 10'h03F
`define PRE_DIV256 10'h0FF
`define PRE_DIV1024 10'h3FF
`endif

// >>> inc/timer16_pkg.sv
// types shared by the timer core and its capture filter
// assumes timer16_map.svh defines the numeric constants
package timer16_pkg;
    typedef enum logic [2:0] {
        CS_NONE = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
        CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
    } clk_sel_t;
    typedef enum logic [2:0] {
        CEIL_MAX = 3'h0, CEIL_FF = 3'h1, CEIL_1FF = 3'h2, CEIL_3FF = 3'h3,
        CEIL_CMP0 = 3'h4, CEIL_CAP = 3'h5, CEIL_CMP0_PWM = 3'h6, CEIL_CAP_PWM = 3'h7
    } ceil_sel_t;
    typedef struct packed {
        logic sel;
        logic wr;
        logic [11:0] addr;
    } bus_req_t;
endpackage

// >>> core/capture_filter.sv
// capture input conditioner: optional spike filter and edge detector
// assumes inputs synchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "timer16_map.svh"
module capture_filter
    import timer16_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic raw_in, // selected capture source
    input wire logic filt_en, // enable spike filter
    input wire logic rise_edge, // capture on rising edge
    output logic event_out // one-cycle capture event
);
    logic [`FILT_LEN-1:0] hist_ff, nxt_hist;
    logic level_ff, nxt_level;
    logic event_ff, nxt_event;

    // ----------------------------------------
    // filter and edge
    // ----------------------------------------
    always_comb begin
        logic cand;
        cand = level_ff;
        nxt_hist = {hist_ff[`FILT_LEN-2:0], raw_in};
        // spike filter
        // level moves only after FILT_LEN equal samples; costs FILT_LEN-1 cycles of added latency
        if (!filt_en) begin
            cand = raw_in;
        end else if (&nxt_hist) begin
            cand = 1'b1;
        end else if (~|nxt_hist) begin
            cand = 1'b0;
        end
        nxt_level = cand;
        nxt_event = (cand != level_ff) && (cand == rise_edge);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hist_ff <= '0;
            level_ff <= 1'b0;
            event_ff <= 1'b0;
        end else begin
            hist_ff <= nxt_hist;
            level_ff <= nxt_level;
            event_ff <= nxt_event;
        end
    end
    assign event_out = event_ff;

    filt_cover_c: cover property (@(posedge clk) disable iff (!arst_n) filt_en && event_ff);
endmodule
`default_nettype wire

// >>> core/timer16_core.sv
// 16-bit timer core: counter, three compare channels, capture, ahb-lite slave
// assumes a single ahb-lite master, word accesses, synchronous pins
//
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "timer16_map.svh"
module timer16_core
    import timer16_pkg::*;
(
    input wire logic clk, // 50 MHz system clock
    input wire logic arst_n, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic external_tick_pin, // external count clock
    input wire logic capture_pin, // capture input
    input wire logic comparator_in, // analog comparator output
    output logic [2:0] compare_output_pin, // waveform outputs
    output logic count_floor, // counter at zero
    output logic [`FLAG_W-1:0] irq_req // masked requests
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] ctrl_ff [3];
    logic [7:0] nxt_ctrl [3];
    logic [7:0] hold_ff, nxt_hold;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [15:0] cmp_buf_ff [3];
    logic [15:0] nxt_cmp_buf [3];
    logic [15:0] cmp_act_ff [3];
    logic [15:0] nxt_cmp_act [3];
    logic [15:0] cap_ff, nxt_cap;
    logic [`FLAG_W-1:0] flag_ff, nxt_flag;
    logic [`FLAG_W-1:0] mask_ff, nxt_mask;
    logic [7:0] power_ff, nxt_power;
    logic [9:0] pre_ff, nxt_pre;
    logic ext_ff, nxt_ext;
    logic [2:0] wave_ff, nxt_wave;
    logic floor_ff, nxt_floor;
    logic [`FLAG_W-1:0] irq_ff, nxt_irq;
    logic [31:0] rdata_ff, nxt_rdata;
    bus_req_t req_ff, nxt_req;
    logic cap_event;
    logic tick;

    clk_sel_t cs;
    ceil_sel_t ceil_mode;
    assign cs = clk_sel_t'(ctrl_ff[1][`CTRL_B_CS_LSB +: 3]);
    assign ceil_mode = ceil_sel_t'(ctrl_ff[1][`CTRL_B_CEIL_LSB +: 3]);

    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ofs);
        is_addr = (a == ofs);
    endfunction

    // ----------------------------------------
    // bus address phase
    // ----------------------------------------
    always_comb begin
        nxt_req.sel = hsel && hready && htrans[1] && (hsize == 3'h2);
        nxt_req.wr = hwrite;
        nxt_req.addr = haddr[11:0];
    end

    // ----------------------------------------
    // tick generation
    // ----------------------------------------
    always_comb begin
        logic [9:0] lim;
        lim = '0;
        nxt_pre = pre_ff + 10'h001;
        nxt_ext = external_tick_pin;
        tick = 1'b0;
        case (cs)
            CS_DIV8: lim = `PRE_DIV8;
            CS_DIV64: lim = `PRE_DIV64;
            CS_DIV256: lim = `PRE_DIV256;
            CS_DIV1024: lim = `PRE_DIV1024;
            default: lim = '0;
        endcase
        case (cs)
            CS_DIV1: tick = 1'b1;
            CS_EXT_FALL: tick = ext_ff && !external_tick_pin;
            CS_EXT_RISE: tick = !ext_ff && external_tick_pin;
            CS_NONE: tick = 1'b0;
            default: tick = ((pre_ff & lim) == lim);
        endcase
        if (power_ff[0]) begin
            tick = 1'b0;
            nxt_pre = '0;
        end
        if (cs == CS_NONE) begin
            tick = 1'b0;
        end
    end

    // ----------------------------------------
    // counter, compare, capture, registers
    // ----------------------------------------
    always_comb begin
        logic [15:0] ceil;
        logic [11:0] a;
        logic wr_en;
        logic cnt_wr;
        logic at_ceil;
        logic [`FLAG_W-1:0] set_f;
        logic [`FLAG_W-1:0] clr_f;
        logic [7:0] wb;
        ceil = `COUNT_MAX;
        a = req_ff.addr;
        wb = hwdata[7:0];
        wr_en = req_ff.sel && req_ff.wr;
        cnt_wr = 1'b0;
        set_f = '0;
        clr_f = '0;
        nxt_ctrl = ctrl_ff;
        nxt_hold = hold_ff;
        nxt_cnt = cnt_ff;
        nxt_cmp_buf = cmp_buf_ff;
        nxt_cmp_act = cmp_act_ff;
        nxt_cap = cap_ff;
        nxt_mask = mask_ff;
        nxt_power = power_ff;
        nxt_wave = wave_ff;
        nxt_rdata = '0;
        case (ceil_mode)
            CEIL_FF: ceil = `CEIL_8BIT;
            CEIL_1FF: ceil = `CEIL_9BIT;
            CEIL_3FF: ceil = `CEIL_10BIT;
            CEIL_CMP0, CEIL_CMP0_PWM: ceil = cmp_act_ff[0];
            CEIL_CAP, CEIL_CAP_PWM: ceil = cap_ff;
            default: ceil = `COUNT_MAX;
        endcase
        at_ceil = (cnt_ff == ceil);
        if (tick) begin
            nxt_cnt = at_ceil ? `COUNT_FLOOR : cnt_ff + 16'h0001;
            if (at_ceil || cnt_ff == `COUNT_MAX) begin
                set_f[`FLAG_OVF_BIT] = 1'b1;
                nxt_cmp_act = cmp_buf_ff;
            end
            for (int i = 0; i < 3; i++) begin
                if (cnt_ff == cmp_act_ff[i]) begin
                    set_f[`FLAG_CMP_LSB + i] = 1'b1;
                    nxt_wave[i] = 1'b0;
                end
            end
            if (at_ceil) begin
                nxt_wave = 3'h7;
            end
            // no pwm when first compare is ceiling
            if (ceil_mode == CEIL_CMP0_PWM) begin
                nxt_wave[0] = 1'b0;
            end
        end
        if (cap_event && !power_ff[0]) begin
            nxt_cap = cnt_ff;
            set_f[`FLAG_CAP_BIT] = 1'b1;
        end
        if (wr_en) begin
            if (is_addr(a, `OFS_CTRL_A)) begin
                nxt_ctrl[0] = wb;
            end else if (is_addr(a, `OFS_CTRL_B)) begin
                nxt_ctrl[1] = wb;
            end else if (is_addr(a, `OFS_CTRL_C)) begin
                nxt_ctrl[2] = wb;
            end else if (is_addr(a, `OFS_CNT_HI) || is_addr(a, `OFS_CMP0_HI)
                    || is_addr(a, `OFS_CMP1_HI) || is_addr(a, `OFS_CMP2_HI)
                    || is_addr(a, `OFS_CAP_HI)) begin
                nxt_hold = wb;
            end else if (is_addr(a, `OFS_CNT_LO)) begin
                nxt_cnt = {hold_ff, wb};
                cnt_wr = 1'b1;
            end else if (is_addr(a, `OFS_CMP0_LO)) begin
                nxt_cmp_buf[0] = {hold_ff, wb};
            end else if (is_addr(a, `OFS_CMP1_LO)) begin
                nxt_cmp_buf[1] = {hold_ff, wb};
            end else if (is_addr(a, `OFS_CMP2_LO)) begin
                nxt_cmp_buf[2] = {hold_ff, wb};
            end else if (is_addr(a, `OFS_CAP_LO)) begin
                nxt_cap = {hold_ff, wb};
            end else if (is_addr(a, `OFS_FLAG)) begin
                clr_f = wb[`FLAG_W-1:0];
            end else if (is_addr(a, `OFS_MASK)) begin
                nxt_mask = wb[`FLAG_W-1:0];
            end else if (is_addr(a, `OFS_POWER)) begin
                nxt_power = {7'h00, wb[0]};
            end
        end
        // CEIL_MAX and CEIL_CAP ceilings load compare buffer at once
        if (ceil_mode == CEIL_MAX || ceil_mode == CEIL_CAP) begin
            for (int i = 0; i < 3; i++) begin
                nxt_cmp_act[i] = nxt_cmp_buf[i];
            end
        end
        if (cnt_wr) begin
            set_f[`FLAG_OVF_BIT] = 1'b0;
        end
        nxt_flag = (flag_ff & ~clr_f) | set_f;
        nxt_irq = nxt_flag & nxt_mask;
        nxt_floor = (nxt_cnt == `COUNT_FLOOR);
        // read decoded in the address phase so data stands in the data phase;
        // sources are next values so a write finishing now is seen
        if (nxt_req.sel && !nxt_req.wr) begin
            if (is_addr(nxt_req.addr, `OFS_CTRL_A)) begin
                nxt_rdata = {24'h000000, nxt_ctrl[0]};
            end else if (is_addr(nxt_req.addr, `OFS_CTRL_B)) begin
                nxt_rdata = {24'h000000, nxt_ctrl[1]};
            end else if (is_addr(nxt_req.addr, `OFS_CTRL_C)) begin
                nxt_rdata = {24'h000000, nxt_ctrl[2]};
            end else if (is_addr(nxt_req.addr, `OFS_CNT_LO)) begin
                nxt_rdata = {24'h000000, nxt_cnt[7:0]};
                nxt_hold = nxt_cnt[15:8];
            end else if (is_addr(nxt_req.addr, `OFS_CAP_LO)) begin
                nxt_rdata = {24'h000000, nxt_cap[7:0]};
                nxt_hold = nxt_cap[15:8];
            end else if (is_addr(nxt_req.addr, `OFS_CNT_HI)
                    || is_addr(nxt_req.addr, `OFS_CAP_HI)) begin
                nxt_rdata = {24'h000000, nxt_hold};
            end else if (is_addr(nxt_req.addr, `OFS_CMP0_LO)) begin
                nxt_rdata = {24'h000000, nxt_cmp_buf[0][7:0]};
            end else if (is_addr(nxt_req.addr, `OFS_CMP0_HI)) begin
                nxt_rdata = {24'h000000, nxt_cmp_buf[0][15:8]};
            end else if (is_addr(nxt_req.addr, `OFS_CMP1_LO)) begin
                nxt_rdata = {24'h000000, nxt_cmp_buf[1][7:0]};
            end else if (is_addr(nxt_req.addr, `OFS_CMP1_HI)) begin
                nxt_rdata = {24'h000000, nxt_cmp_buf[1][15:8]};
            end else if (is_addr(nxt_req.addr, `OFS_CMP2_LO)) begin
                nxt_rdata = {24'h000000, nxt_cmp_buf[2][7:0]};
            end else if (is_addr(nxt_req.addr, `OFS_CMP2_HI)) begin
                nxt_rdata = {24'h000000, nxt_cmp_buf[2][15:8]};
            end else if (is_addr(nxt_req.addr, `OFS_FLAG)) begin
                nxt_rdata = {27'h0000000, nxt_flag};
            end else if (is_addr(nxt_req.addr, `OFS_MASK)) begin
                nxt_rdata = {27'h0000000, nxt_mask};
            end else if (is_addr(nxt_req.addr, `OFS_POWER)) begin
                nxt_rdata = {24'h000000, nxt_power};
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 3; i++) begin
                ctrl_ff[i] <= 8'h00;
                cmp_buf_ff[i] <= 16'h0000;
                cmp_act_ff[i] <= 16'h0000;
            end
            hold_ff <= 8'h00;
            cnt_ff <= 16'h0000;
            cap_ff <= 16'h0000;
            flag_ff <= '0;
            mask_ff <= '0;
            power_ff <= `POWER_RST;
            pre_ff <= '0;
            ext_ff <= 1'b0;
            wave_ff <= 3'h0;
            floor_ff <= 1'b1;
            irq_ff <= '0;
            rdata_ff <= 32'h00000000;
            req_ff <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            cmp_buf_ff <= nxt_cmp_buf;
            cmp_act_ff <= nxt_cmp_act;
            hold_ff <= nxt_hold;
            cnt_ff <= nxt_cnt;
            cap_ff <= nxt_cap;
            flag_ff <= nxt_flag;
            mask_ff <= nxt_mask;
            power_ff <= nxt_power;
            pre_ff <= nxt_pre;
            ext_ff <= nxt_ext;
            wave_ff <= nxt_wave;
            floor_ff <= nxt_floor;
            irq_ff <= nxt_irq;
            rdata_ff <= nxt_rdata;
            req_ff <= nxt_req;
        end
    end

    capture_filter u_cap (
        .clk(clk),
        .arst_n(arst_n),
        .raw_in(ctrl_ff[1][`CTRL_B_CAPSRC_BIT] ? comparator_in : capture_pin),
        .filt_en(ctrl_ff[1][`CTRL_B_FILT_BIT]),
        .rise_edge(ctrl_ff[2][`CTRL_C_CAPEDGE_BIT]),
        .event_out(cap_event)
    );

    // zero-wait slave: read data registered at the end of the address phase
    assign hrdata = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign compare_output_pin = wave_ff;
    assign count_floor = floor_ff;
    assign irq_req = irq_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic at_ceil_cov;
    assign at_ceil_cov = flag_ff[`FLAG_OVF_BIT];

    stop_no_count_a: assert property ((cs == CS_NONE || power_ff[0]) && !(req_ff.sel && req_ff.wr)
        |=> cnt_ff == $past(cnt_ff)) else $error("counter moved while stopped");
    gate_stop_a: assert property (power_ff[0] |-> !tick)
        else $error("tick while gated");
    low_write_a: assert property (req_ff.sel && req_ff.wr && req_ff.addr == `OFS_CNT_LO
        |=> cnt_ff == {$past(hold_ff), $past(hwdata[7:0])})
        else $error("counter low write wrong");
    high_write_a: assert property (req_ff.sel && req_ff.wr && req_ff.addr == `OFS_CMP1_HI
        |=> cmp_buf_ff[1] == $past(cmp_buf_ff[1]) && hold_ff == $past(hwdata[7:0]))
        else $error("high write leaked");
    low_read_a: assert property (req_ff.sel && !req_ff.wr && req_ff.addr == `OFS_CAP_LO
        |-> hold_ff == $past(nxt_cap[15:8]) && hrdata[7:0] == $past(nxt_cap[7:0]))
        else $error("holding not filled");
    cmp_read_a: assert property (req_ff.sel && !req_ff.wr && req_ff.addr == `OFS_CMP2_HI
        && !$past(req_ff.sel) |-> hold_ff == $past(hold_ff)
        && hrdata[7:0] == cmp_buf_ff[2][15:8])
        else $error("compare read used holding");
    match_flag_a: assert property (tick && cnt_ff == cmp_act_ff[1]
        |=> flag_ff[`FLAG_CMP_LSB + 1]) else $error("match flag missed");
    capture_latch_a: assert property (cap_event && !power_ff[0] && !(req_ff.sel && req_ff.wr)
        |=> cap_ff == $past(cnt_ff) && flag_ff[`FLAG_CAP_BIT])
        else $error("capture missed");
    ceil_wrap_a: assert property (tick && ceil_mode == CEIL_FF && cnt_ff == `CEIL_8BIT
        && !(req_ff.sel && req_ff.wr) |=> cnt_ff == `COUNT_FLOOR ##0 count_floor)
        else $error("ceiling wrap wrong");
    no_pwm_a: assert property (ceil_mode == CEIL_CMP0_PWM && tick
        |=> !compare_output_pin[0]) else $error("pwm on ceiling channel");
    irq_mask_a: assert property (##1 irq_req == $past(nxt_flag & nxt_mask))
        else $error("masked request wrong");

    wrap_c: cover property (tick && at_ceil_cov);
    capture_c: cover property (cap_event);
    cnt_write_c: cover property (req_ff.sel && req_ff.wr && req_ff.addr == `OFS_CNT_LO && tick);
endmodule
`default_nettype wire

// >>> bench/cpu_bus_model.sv
// processor-side model: single-word ahb-lite transfers and 16-bit pair access
// assumes hready is the one slave's hreadyout; calls start just after an edge
`timescale 1ns/10ps
`default_nettype none
`include "timer16_map.svh"
module cpu_bus_model (
    input wire logic clk, // system clock
    input wire logic hready, // slave ready
    input wire logic [31:0] hrdata, // read data
    output logic hsel, // slave select
    output logic [31:0] haddr, // byte address
    output logic [1:0] htrans, // transfer type
    output logic hwrite, // write flag
    output logic [2:0] hsize, // always word
    output logic [31:0] hwdata // write data
);
    // ----------------
    // bus transfers
    // ----------------
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        // wait states allowed: data held until ready is seen again
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] unused;
        xfer(1'b1, a, wd, unused);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] rd_v);
        xfer(1'b0, a, 32'h0, rd_v);
    endtask
    task automatic wr16(input logic [11:0] a, input logic [15:0] val);
        wr(a + 12'h004, {24'h0, val[15:8]});
        wr(a, {24'h0, val[7:0]});
    endtask
    task automatic rd16(input logic [11:0] a, output logic [15:0] val);
        logic [31:0] lo;
        logic [31:0] hi;
        rd(a, lo);
        rd(a + 12'h004, hi);
        val = {hi[7:0], lo[7:0]};
    endtask
    task automatic power_on;
        wr(`OFS_POWER, 32'h0);
    endtask
endmodule
`default_nettype wire

// >>> bench/sixteen_bit_timer_core_tb_top.sv
// self-checking bench for the timer core, driven through the bus model
// assumes timer16_core and cpu_bus_model are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "timer16_map.svh"
module sixteen_bit_timer_core_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel, hwrite, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic external_tick_pin = 1'b0;
    logic capture_pin = 1'b0;
    logic comparator_in = 1'b0;
    logic [2:0] compare_output_pin;
    logic count_floor;
    logic [4:0] irq_req;
    logic [2:0] seen_hi = 3'h0;
    logic [2:0] seen_lo = 3'h0;
    logic [31:0] d;
    logic [15:0] v;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    int div [5] = '{1, 8, 64, 256, 1024};
    logic [2:0] ceil_mode [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [15:0] ceil_top [7] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h0300, 16'h0250,
        16'h0300, 16'h0250};
    always #10 clk = ~clk;
    timer16_core i_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .external_tick_pin(external_tick_pin), .capture_pin(capture_pin),
        .comparator_in(comparator_in), .compare_output_pin(compare_output_pin),
        .count_floor(count_floor), .irq_req(irq_req));
    cpu_bus_model i_cpu (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    // ----------------
    // helpers
    // ----------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_in(input string what, input logic [15:0] lo, input logic [15:0] hi,
        input logic [15:0] got);
        checks_done++;
        if ($isunknown(got) || got < lo || got > hi) begin
            n_mismatch++;
            $display("wrong value %s expected %h to %h seen %h", what, lo, hi, got);
        end
    endtask
    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        i_cpu.rd(a, d);
        chk(what, exp, d);
    endtask
    task automatic rd16c(input string what, input logic [11:0] a, input logic [15:0] exp);
        i_cpu.rd16(a, v);
        chk(what, {16'h0, exp}, {16'h0, v});
    endtask
    task automatic rd16in(input string what, input logic [11:0] a, input logic [15:0] lo,
        input logic [15:0] hi);
        i_cpu.rd16(a, v);
        chk_in(what, lo, hi, v);
    endtask
    // pin levels sampled each cycle so waveform activity can be judged afterwards
    task automatic run(input int n);
        repeat (n) begin
            @(posedge clk);
            seen_hi |= compare_output_pin;
            seen_lo |= ~compare_output_pin;
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // whole sequence needs about 19400 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    // ----------------
    // test sequence
    // ----------------
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk("floor after reset", 32'h1, {31'h0, count_floor});
        rdc("power gate", `OFS_POWER, 32'h1);
        rdc("unmapped", 12'h040, 32'h0);
        i_cpu.wr(`OFS_CTRL_A, 32'hA5);
        rdc("ctrl_a", `OFS_CTRL_A, 32'hA5);
        i_cpu.power_on();
        $display("test reset done");
        i_cpu.wr(`OFS_CNT_HI, 32'h12);
        rdc("cnt lo", `OFS_CNT_LO, 32'h0);
        rdc("cnt hi copy", `OFS_CNT_HI, 32'h0);
        i_cpu.wr16(`OFS_CNT_LO, 16'h1234);
        run(20);
        rd16c("stopped cnt", `OFS_CNT_LO, 16'h1234);
        i_cpu.wr(`OFS_CNT_HI, 32'hAB);
        i_cpu.wr(`OFS_CMP1_LO, 32'h11);
        i_cpu.wr(`OFS_CMP2_LO, 32'h22);
        rd16c("cmp1", `OFS_CMP1_LO, 16'hAB11);
        rd16c("cmp2", `OFS_CMP2_LO, 16'hAB22);
        rdc("cnt lo", `OFS_CNT_LO, 32'h34);
        rdc("cmp2 hi", `OFS_CMP2_HI, 32'hAB);
        rdc("held hi", `OFS_CNT_HI, 32'h12);
        $display("test holding done");
        i_cpu.wr16(`OFS_CNT_LO, 16'hFFF0);
        i_cpu.wr(`OFS_CTRL_B, 32'h1);
        run(30);
        i_cpu.wr(`OFS_CTRL_B, 32'h0);
        rd16in("wrap", `OFS_CNT_LO, 16'h000A, 16'h0020);
        rdc("wrap flags", `OFS_FLAG, 32'h03);
        i_cpu.wr16(`OFS_CMP0_LO, 16'h0010);
        i_cpu.wr16(`OFS_CMP1_LO, 16'h0020);
        i_cpu.wr16(`OFS_CMP2_LO, 16'h0030);
        i_cpu.wr16(`OFS_CNT_LO, 16'h0000);
        i_cpu.wr(`OFS_FLAG, 32'h1F);
        i_cpu.wr(`OFS_MASK, 32'h1F);
        seen_hi = 3'h0;
        seen_lo = 3'h0;
        i_cpu.wr(`OFS_CTRL_B, 32'h9);
        run(600);
        i_cpu.wr(`OFS_CTRL_B, 32'h8);
        chk("pins high", 32'h7, {29'h0, seen_hi});
        chk("pins low", 32'h7, {29'h0, seen_lo});
        rdc("flags", `OFS_FLAG, 32'h0F);
        chk("irq", 32'h0F, {27'h0, irq_req});
        i_cpu.wr(`OFS_MASK, 32'h04);
        run(2);
        chk("irq masked", 32'h04, {27'h0, irq_req});
        i_cpu.wr(`OFS_FLAG, 32'h0B);
        rdc("flags cleared", `OFS_FLAG, 32'h04);
        i_cpu.wr16(`OFS_CNT_LO, 16'h0005);
        run(2);
        chk("floor low", 32'h0, {31'h0, count_floor});
        i_cpu.wr16(`OFS_CNT_LO, 16'h0000);
        run(2);
        chk("floor high", 32'h1, {31'h0, count_floor});
        $display("test flags done");
        i_cpu.wr(`OFS_CTRL_C, 32'h1);
        i_cpu.wr(`OFS_CTRL_B, 32'h40);
        i_cpu.wr16(`OFS_CNT_LO, 16'h4321);
        i_cpu.wr(`OFS_FLAG, 32'h1F);
        capture_pin <= 1'b1;
        run(2);
        capture_pin <= 1'b0;
        run(10);
        rdc("spike", `OFS_FLAG, 32'h0);
        capture_pin <= 1'b1;
        run(8);
        capture_pin <= 1'b0;
        run(10);
        rd16c("capture", `OFS_CAP_LO, 16'h4321);
        rdc("capture flag", `OFS_FLAG, 32'h10);
        i_cpu.wr(`OFS_CTRL_B, 32'h80);
        i_cpu.wr16(`OFS_CNT_LO, 16'h0250);
        comparator_in <= 1'b1;
        run(10);
        rd16c("comparator capture", `OFS_CAP_LO, 16'h0250);
        $display("test capture done");
        i_cpu.wr(`OFS_CTRL_B, 32'h0);
        i_cpu.wr16(`OFS_CMP0_LO, 16'h0300);
        foreach (ceil_mode[k]) begin
            i_cpu.wr16(`OFS_CNT_LO, 16'h0000);
            i_cpu.wr(`OFS_CTRL_B, {26'h0, ceil_mode[k], 3'h1});
            run(1100);
            i_cpu.wr(`OFS_CTRL_B, {26'h0, ceil_mode[k], 3'h0});
            rd16in("ceiling", `OFS_CNT_LO, 16'h0000, ceil_top[k]);
        end
        $display("test ceiling done");
        foreach (div[k]) begin
            i_cpu.wr16(`OFS_CNT_LO, 16'h0000);
            i_cpu.wr(`OFS_CTRL_B, 32'(k + 1));
            run(2100);
            i_cpu.wr(`OFS_CTRL_B, 32'h0);
            rd16in("prescale", `OFS_CNT_LO, 16'(2100 / div[k] - 1), 16'(2140 / div[k] + 1));
        end
        i_cpu.wr(`OFS_CTRL_B, 32'h1);
        i_cpu.wr16(`OFS_CNT_LO, 16'h8000);
        i_cpu.wr(`OFS_CTRL_B, 32'h0);
        rd16in("write priority", `OFS_CNT_LO, 16'h8000, 16'h8004);
        for (int e = 6; e < 8; e++) begin
            i_cpu.wr16(`OFS_CNT_LO, 16'h0000);
            i_cpu.wr(`OFS_CTRL_B, 32'(e));
            repeat (10) begin
                external_tick_pin <= 1'b1;
                run(4);
                external_tick_pin <= 1'b0;
                run(4);
            end
            run(8);
            i_cpu.wr(`OFS_CTRL_B, 32'h0);
            rd16c("pin ticks", `OFS_CNT_LO, 16'h000A);
        end
        $display("test clock select done");
        wrap_up();
    end
endmodule
`default_nettype wire
